// *** rtc_alarm_pkg.sv ***
package rtc_alarm_pkg;

  // ---------------------------------------------------------------
  // Register map (register bus address, 4 bits)
  // ---------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam logic [3:0] OFS_ALARM_SEC = 4'h1;
  localparam logic [3:0] OFS_ALARM_MIN = 4'h3;
  localparam logic [3:0] OFS_ALARM_HOUR = 4'h5;
  localparam logic [3:0] OFS_ALARM_DATE = 4'h7;
  localparam logic [3:0] OFS_IRQ_CTRL = 4'hC;
  localparam logic [3:0] OFS_FLAGS = 4'hD;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int MASK_HI_BIT = 7;
  localparam int MASK_LO_BIT = 6;
  localparam int ALARM_IRQ_EN_BIT = 3;
  localparam int SUPPLY_IRQ_EN_BIT = 2;
  localparam int BACKUP_ALARM_EN_BIT = 1;
  localparam int ALARM_FLAG_BIT = 3;
  localparam int SUPPLY_FLAG_BIT = 2;
  localparam int CELL_OK_BIT = 0;
  localparam logic [7:0] ALARM_RST = 8'h00;
  localparam logic [7:0] IRQ_CTRL_RST = 8'h00;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_KHZ = 10000;
  localparam int FAIL_WARN_US = 100;
  localparam int FAIL_WARN_CYC = (FAIL_WARN_US * CLK_KHZ) / 1000;
  localparam logic [1:0] SYNC_SETTLE = 2'h3;

  typedef enum logic [1:0] {
    PWR_OK = 2'b00,
    PWR_WARN = 2'b01,
    PWR_RESET = 2'b10
  } pwr_state_t;

endpackage

// *** alarm_cmp_if.sv ***
`timescale 1ns/100ps
`default_nettype none

interface alarm_cmp_if;
  logic [7:0] alarm_byte;
  logic [7:0] time_byte;
  logic match;
  modport cmp (input alarm_byte, input time_byte, output match);
  modport ctl (output alarm_byte, output time_byte, input match);
endinterface

`default_nettype wire

// *** alarm_byte_cmp.sv ***
`timescale 1ns/100ps
`default_nettype none

module alarm_byte_cmp
(
  alarm_cmp_if.cmp port
);

  // ---------------------------------------------------------------
  // One compare byte; both mask bits set drops it from the match
  // ---------------------------------------------------------------
  logic masked;

  always_comb
  begin
    masked = port.alarm_byte[rtc_alarm_pkg::MASK_HI_BIT] & port.alarm_byte[rtc_alarm_pkg::MASK_LO_BIT];
    port.match = masked | (port.alarm_byte == port.time_byte);
  end

endmodule

`default_nettype wire

// *** rtc_alarm_flags.sv ***
// Summary of operation
// - Every update cycle the date, hour, minute and second are compared with the four alarm bytes.
// - The alarm match flag sets only when every unmasked byte equals its clock byte in an update cycle.
// - A set alarm match flag with the alarm interrupt enabled pulls the interrupt line low.
// - Reading the flags register clears the pending alarm.
// - An alarm byte with both of its top two bits at 1 is left out of the match.
// - Masking selects a rate of once a second, minute, hour, day or on a full date match.
// - In battery backup the interrupt line is normally released.
// - With backup alarm enabled, an enabled alarm match still pulls the line low in backup.
// - A supply drop to the fail point sets the supply fail flag.
// - A set supply fail flag with its enable set pulls the interrupt line low.
// - The supply fail interrupt leads the processor reset and deselect by a fixed warning time.
// - At power-up the cell is tested and the cell ok flag is cleared if it reads low.
// - Flags set whatever their enables; an interrupt needs flag and enable together.
// - A flags read clears all event flags together and releases the interrupt line.
//
// The implementer's own choice: strobed register access.
`timescale 1ns/100ps
`default_nettype none

module rtc_alarm_flags
#(
  parameter int WARN_CYC = rtc_alarm_pkg::FAIL_WARN_CYC
)
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [7:0] rdata,
  input wire logic update_stb,
  input wire logic [7:0] time_sec,
  input wire logic [7:0] time_min,
  input wire logic [7:0] time_hour,
  input wire logic [7:0] time_date,
  input wire logic supply_fail_pin,
  input wire logic backup_pin,
  input wire logic cell_low_pin,
  output logic irq_n_o,
  output logic irq_n_oe,
  output logic cpu_reset_n,
  output logic chip_deselect
);

  localparam int CNT_W = $clog2(WARN_CYC + 1);
  localparam logic [CNT_W-1:0] WARN_LAST = CNT_W'(WARN_CYC - 1);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [2:0] sync1_ff;
  logic [2:0] sync2_ff;
  logic fail_prev_ff;
  logic fail_s;
  logic backup_s;
  logic cell_low_s;
  logic fail_rise;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      sync1_ff <= 3'h0;
      sync2_ff <= 3'h0;
      fail_prev_ff <= 1'b0;
    end
    else
    begin
      sync1_ff <= {cell_low_pin, backup_pin, supply_fail_pin};
      sync2_ff <= sync1_ff;
      fail_prev_ff <= sync2_ff[0];
    end
  end

  always_comb
  begin
    fail_s = sync2_ff[0];
    backup_s = sync2_ff[1];
    cell_low_s = sync2_ff[2];
    fail_rise = fail_s & ~fail_prev_ff;
  end

  // ---------------------------------------------------------------
  // Alarm byte compare
  // ---------------------------------------------------------------
  logic [7:0] alarm_ff [4];
  logic [7:0] nxt_alarm [4];
  logic [7:0] time_bytes [4];
  logic [3:0] byte_match;
  logic all_match;

  assign time_bytes = '{time_sec, time_min, time_hour, time_date};

  for (genvar i = 0; i < 4; i++)
  begin : g_cmp
    alarm_cmp_if cmp_bus ();
    assign cmp_bus.alarm_byte = alarm_ff[i];
    assign cmp_bus.time_byte = time_bytes[i];
    assign byte_match[i] = cmp_bus.match;
    alarm_byte_cmp u_cmp (.port(cmp_bus.cmp));
  end

  assign all_match = &byte_match;

  // ---------------------------------------------------------------
  // Register file and flags
  // ---------------------------------------------------------------
  logic [7:0] irq_ctrl_ff;
  logic [7:0] nxt_irq_ctrl;
  logic alarm_match_flag_ff;
  logic nxt_alarm_match_flag;
  logic supply_fail_flag_ff;
  logic nxt_supply_fail_flag;
  logic cell_ok_flag_ff;
  logic nxt_cell_ok_flag;
  logic cell_checked_ff;
  logic nxt_cell_checked;
  logic [1:0] settle_ff;
  logic [1:0] nxt_settle;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic flags_rd;
  logic alarm_irq_enable;
  logic supply_fail_irq_enable;
  logic backup_alarm_enable;

  always_comb
  begin
    alarm_irq_enable = irq_ctrl_ff[rtc_alarm_pkg::ALARM_IRQ_EN_BIT];
    supply_fail_irq_enable = irq_ctrl_ff[rtc_alarm_pkg::SUPPLY_IRQ_EN_BIT];
    backup_alarm_enable = irq_ctrl_ff[rtc_alarm_pkg::BACKUP_ALARM_EN_BIT];
    flags_rd = rd_stb && (addr == rtc_alarm_pkg::OFS_FLAGS);
  end

  always_comb
  begin
    nxt_alarm = alarm_ff;
    nxt_irq_ctrl = irq_ctrl_ff;
    nxt_alarm_match_flag = alarm_match_flag_ff;
    nxt_supply_fail_flag = supply_fail_flag_ff;
    nxt_cell_ok_flag = cell_ok_flag_ff;
    nxt_cell_checked = cell_checked_ff;
    nxt_settle = settle_ff;
    nxt_rdata = 8'h00;
    if (wr_stb)
    begin
      unique case (addr)
        rtc_alarm_pkg::OFS_ALARM_SEC: nxt_alarm[0] = wdata;
        rtc_alarm_pkg::OFS_ALARM_MIN: nxt_alarm[1] = wdata;
        rtc_alarm_pkg::OFS_ALARM_HOUR: nxt_alarm[2] = wdata;
        rtc_alarm_pkg::OFS_ALARM_DATE: nxt_alarm[3] = wdata;
        rtc_alarm_pkg::OFS_IRQ_CTRL: nxt_irq_ctrl = wdata;
        default: nxt_irq_ctrl = irq_ctrl_ff;
      endcase
    end
    if (rd_stb)
    begin
      unique case (addr)
        rtc_alarm_pkg::OFS_ALARM_SEC: nxt_rdata = alarm_ff[0];
        rtc_alarm_pkg::OFS_ALARM_MIN: nxt_rdata = alarm_ff[1];
        rtc_alarm_pkg::OFS_ALARM_HOUR: nxt_rdata = alarm_ff[2];
        rtc_alarm_pkg::OFS_ALARM_DATE: nxt_rdata = alarm_ff[3];
        rtc_alarm_pkg::OFS_IRQ_CTRL: nxt_rdata = irq_ctrl_ff;
        rtc_alarm_pkg::OFS_FLAGS:
        begin
          nxt_rdata[rtc_alarm_pkg::ALARM_FLAG_BIT] = alarm_match_flag_ff;
          nxt_rdata[rtc_alarm_pkg::SUPPLY_FLAG_BIT] = supply_fail_flag_ff;
          nxt_rdata[rtc_alarm_pkg::CELL_OK_BIT] = cell_ok_flag_ff;
        end
        default: nxt_rdata = 8'h00;
      endcase
    end
    // Clear first, then set: an event in the read cycle survives it
    if (flags_rd)
    begin
      nxt_alarm_match_flag = 1'b0;
      nxt_supply_fail_flag = 1'b0;
    end
    if (update_stb && all_match)
    begin
      nxt_alarm_match_flag = 1'b1;
    end
    if (fail_rise)
    begin
      nxt_supply_fail_flag = 1'b1;
    end
    // Cell level is caught once, after the synchroniser has filled
    if (!cell_checked_ff)
    begin
      if (settle_ff == rtc_alarm_pkg::SYNC_SETTLE)
      begin
        nxt_cell_ok_flag = ~cell_low_s;
        nxt_cell_checked = 1'b1;
      end
      else
      begin
        nxt_settle = settle_ff + 2'h1;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      for (int k = 0; k < 4; k++)
      begin
        alarm_ff[k] <= rtc_alarm_pkg::ALARM_RST;
      end
      irq_ctrl_ff <= rtc_alarm_pkg::IRQ_CTRL_RST;
      alarm_match_flag_ff <= 1'b0;
      supply_fail_flag_ff <= 1'b0;
      cell_ok_flag_ff <= 1'b0;
      cell_checked_ff <= 1'b0;
      settle_ff <= 2'h0;
      rdata_ff <= 8'h00;
    end
    else
    begin
      alarm_ff <= nxt_alarm;
      irq_ctrl_ff <= nxt_irq_ctrl;
      alarm_match_flag_ff <= nxt_alarm_match_flag;
      supply_fail_flag_ff <= nxt_supply_fail_flag;
      cell_ok_flag_ff <= nxt_cell_ok_flag;
      cell_checked_ff <= nxt_cell_checked;
      settle_ff <= nxt_settle;
      rdata_ff <= nxt_rdata;
    end
  end

  // ---------------------------------------------------------------
  // Interrupt line
  // ---------------------------------------------------------------
  logic irq_drive_ff;
  logic nxt_irq_drive;
  logic irq_level_ff;

  always_comb
  begin
    if (backup_s)
    begin
      // Supply fail cannot be reported in backup, only the alarm
      nxt_irq_drive = backup_alarm_enable & alarm_match_flag_ff & alarm_irq_enable;
    end
    else
    begin
      nxt_irq_drive = (alarm_match_flag_ff & alarm_irq_enable)
                    | (supply_fail_flag_ff & supply_fail_irq_enable);
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      irq_drive_ff <= 1'b0;
      irq_level_ff <= 1'b1;
    end
    else
    begin
      irq_drive_ff <= nxt_irq_drive;
      irq_level_ff <= ~nxt_irq_drive;
    end
  end

  // ---------------------------------------------------------------
  // Supply fail warning and processor reset
  // ---------------------------------------------------------------
  rtc_alarm_pkg::pwr_state_t pwr_ff;
  rtc_alarm_pkg::pwr_state_t nxt_pwr;
  logic [CNT_W-1:0] warn_cnt_ff;
  logic [CNT_W-1:0] nxt_warn_cnt;
  logic reset_n_ff;
  logic nxt_reset_n;
  logic deselect_ff;

  always_comb
  begin
    nxt_pwr = pwr_ff;
    nxt_warn_cnt = warn_cnt_ff;
    unique case (pwr_ff)
      rtc_alarm_pkg::PWR_OK:
      begin
        nxt_warn_cnt = '0;
        if (fail_rise)
        begin
          nxt_pwr = rtc_alarm_pkg::PWR_WARN;
        end
      end
      rtc_alarm_pkg::PWR_WARN:
      begin
        if (!fail_s)
        begin
          nxt_pwr = rtc_alarm_pkg::PWR_OK;
        end
        else if (warn_cnt_ff == WARN_LAST)
        begin
          nxt_pwr = rtc_alarm_pkg::PWR_RESET;
        end
        else
        begin
          nxt_warn_cnt = warn_cnt_ff + CNT_W'(1);
        end
      end
      rtc_alarm_pkg::PWR_RESET:
      begin
        if (!fail_s)
        begin
          nxt_pwr = rtc_alarm_pkg::PWR_OK;
        end
      end
      default: nxt_pwr = rtc_alarm_pkg::PWR_OK;
    endcase
    nxt_reset_n = (nxt_pwr != rtc_alarm_pkg::PWR_RESET);
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      pwr_ff <= rtc_alarm_pkg::PWR_OK;
      warn_cnt_ff <= '0;
      reset_n_ff <= 1'b1;
      deselect_ff <= 1'b0;
    end
    else
    begin
      pwr_ff <= nxt_pwr;
      warn_cnt_ff <= nxt_warn_cnt;
      reset_n_ff <= nxt_reset_n;
      deselect_ff <= ~nxt_reset_n;
    end
  end

  assign rdata = rdata_ff;
  assign irq_n_o = irq_level_ff;
  assign irq_n_oe = irq_drive_ff;
  assign cpu_reset_n = reset_n_ff;
  assign chip_deselect = deselect_ff;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  property p_match_sets;
    update_stb && all_match |=> alarm_match_flag_ff;
  endproperty
  a_match_sets: assert property (p_match_sets) else $error("alarm flag missed a match");

  property p_set_needs_match;
    $rose(alarm_match_flag_ff) |-> $past(update_stb) && $past(all_match);
  endproperty
  a_set_needs_match: assert property (p_set_needs_match) else $error("alarm flag set without match");

  property p_mask_all;
    update_stb && (&{alarm_ff[0][7:6], alarm_ff[1][7:6], alarm_ff[2][7:6], alarm_ff[3][7:6]})
      |=> alarm_match_flag_ff;
  endproperty
  a_mask_all: assert property (p_mask_all) else $error("fully masked alarm did not fire");

  property p_alarm_irq;
    alarm_match_flag_ff && alarm_irq_enable && !backup_s |=> irq_n_oe && !irq_n_o;
  endproperty
  a_alarm_irq: assert property (p_alarm_irq) else $error("alarm interrupt not driven");

  property p_read_clears;
    flags_rd && !update_stb && !fail_rise |=> !alarm_match_flag_ff && !supply_fail_flag_ff ##1 !irq_n_oe;
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("flags read did not clear");

  property p_event_kept;
    flags_rd && update_stb && all_match |=> alarm_match_flag_ff;
  endproperty
  a_event_kept: assert property (p_event_kept) else $error("event lost in clearing read");

  property p_backup_quiet;
    backup_s && !backup_alarm_enable |=> !irq_n_oe;
  endproperty
  a_backup_quiet: assert property (p_backup_quiet) else $error("line driven in backup");

  property p_backup_alarm;
    backup_s && backup_alarm_enable && alarm_irq_enable && alarm_match_flag_ff |=> irq_n_oe;
  endproperty
  a_backup_alarm: assert property (p_backup_alarm) else $error("backup alarm not driven");

  property p_fail_flag;
    fail_rise |=> supply_fail_flag_ff;
  endproperty
  a_fail_flag: assert property (p_fail_flag) else $error("supply fail flag not set");

  property p_fail_irq;
    fail_rise ##1 supply_fail_irq_enable && !backup_s |=> irq_n_oe;
  endproperty
  a_fail_irq: assert property (p_fail_irq) else $error("supply fail interrupt late");

  property p_warn_lead;
    pwr_ff == rtc_alarm_pkg::PWR_OK && fail_rise |=> cpu_reset_n [*8];
  endproperty
  a_warn_lead: assert property (p_warn_lead) else $error("reset came without warning time");

  property p_cell_check;
    $rose(cell_checked_ff) |-> cell_ok_flag_ff == !$past(cell_low_s);
  endproperty
  a_cell_check: assert property (p_cell_check) else $error("cell flag wrong at power-up");

  c_alarm: cover property (update_stb && all_match ##1 irq_n_oe);
  c_fail_reset: cover property ($fell(cpu_reset_n));
  c_backup_alarm: cover property (backup_s && irq_n_oe);
  c_clear: cover property (flags_rd && alarm_match_flag_ff);

endmodule

`default_nettype wire

// *** host_bus.sv ***
`timescale 1ns/100ps
`default_nettype none

module host_bus
(
  input wire logic mclk,
  output logic [3:0] addr,
  output logic [7:0] wdata,
  output logic wr_stb,
  output logic rd_stb,
  input wire logic [7:0] rdata,
  input wire logic irq_n_o,
  input wire logic irq_n_oe,
  output logic irq_line
);
  // ----------------------------------------
  // Open-drain line with the board pull-up
  // ----------------------------------------
  assign irq_line = irq_n_oe ? irq_n_o : 1'b1;

  initial
  begin
    addr = 4'h0;
    wdata = 8'h00;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
  end

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge mclk);
    wr_stb <= 1'b0;
    wdata <= ~d;
  endtask

  // Address stands a whole 100 ns cycle before the read is taken
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge mclk);
    rd_stb <= 1'b0;
    @(negedge mclk);
    d = rdata;
  endtask
endmodule

`default_nettype wire

// *** test_rtc_alarm_flags.sv ***
`timescale 1ns/100ps
`default_nettype none

module test_rtc_alarm_flags;
  localparam int WARN = 20;
  logic mclk;
  logic rst;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic wr_stb;
  logic rd_stb;
  logic [7:0] rdata;
  logic update_stb;
  logic [7:0] tim [4];
  logic [7:0] alm [4];
  logic supply_fail_pin;
  logic backup_pin;
  logic cell_low_pin;
  logic irq_n_o;
  logic irq_n_oe;
  logic irq_line;
  logic cpu_reset_n;
  logic chip_deselect;
  logic [7:0] rd_val;
  logic [3:0] ofs [4];
  logic [3:0] mask_tab [5];
  int error_cnt;
  int compares;
  int flip;

  rtc_alarm_flags #(.WARN_CYC(WARN)) i_rtc_alarm_flags (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .update_stb(update_stb), .time_sec(tim[0]),
    .time_min(tim[1]), .time_hour(tim[2]), .time_date(tim[3]), .supply_fail_pin(supply_fail_pin),
    .backup_pin(backup_pin), .cell_low_pin(cell_low_pin), .irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe),
    .cpu_reset_n(cpu_reset_n), .chip_deselect(chip_deselect));

  host_bus i_host_bus (.mclk(mclk), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rdata(rdata), .irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe), .irq_line(irq_line));

  always #50 mclk = ~mclk;

  // ----------------------------------------
  // Expectations and comparisons
  // ----------------------------------------
  function automatic logic exp_hit();
    logic h;
    h = 1'b1;
    for (int k = 0; k < 4; k++)
      if (alm[k][7:6] != 2'b11 && alm[k] != tim[k])
        h = 1'b0;
    return h;
  endfunction

  function automatic logic [7:0] exp_flags(input logic af, input logic pf, input logic ok);
    return {4'h0, af, pf, 1'b0, ok};
  endfunction

  task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_bit(input string what, input logic exp, input logic got);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic upd();
    @(posedge mclk);
    update_stb <= 1'b1;
    @(posedge mclk);
    update_stb <= 1'b0;
  endtask

  task automatic wait_neg(input int n);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask

  task automatic end_test(input string name);
    $display("done: %s", name);
  endtask

  task automatic test_done();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ----------------------------------------
  // Watchdog, far longer than the tests need
  // ----------------------------------------
  initial
  begin
    repeat (5000) @(posedge mclk);
    error_cnt++;
    test_done();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    mclk = 1'b0;
    rst = 1'b1;
    update_stb = 1'b0;
    supply_fail_pin = 1'b0;
    backup_pin = 1'b0;
    cell_low_pin = 1'b0;
    error_cnt = 0;
    compares = 0;
    for (int k = 0; k < 4; k++)
      tim[k] = 8'h00;
    ofs = '{rtc_alarm_pkg::OFS_ALARM_SEC, rtc_alarm_pkg::OFS_ALARM_MIN, rtc_alarm_pkg::OFS_ALARM_HOUR,
      rtc_alarm_pkg::OFS_ALARM_DATE};
    mask_tab = '{4'hF, 4'hE, 4'hC, 4'h8, 4'h0};
    void'($urandom(32248));
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    repeat (8) @(posedge mclk);
    for (int k = 0; k < 4; k++)
    begin
      i_host_bus.rd(ofs[k], rd_val);
      chk_byte("alarm reset", 8'h00, rd_val);
    end
    i_host_bus.rd(4'h0, rd_val);
    chk_byte("unmapped", 8'h00, rd_val);
    i_host_bus.wr(rtc_alarm_pkg::OFS_FLAGS, 8'hFF);
    i_host_bus.rd(rtc_alarm_pkg::OFS_FLAGS, rd_val);
    chk_byte("flags after reset", exp_flags(1'b0, 1'b0, 1'b1), rd_val);
    end_test("reset values");

    // Each of the five mask rates, one matching and one disturbed update each
    i_host_bus.wr(rtc_alarm_pkg::OFS_IRQ_CTRL, 8'h08);
    for (int i = 0; i < 5; i++)
    begin
      for (int k = 0; k < 4; k++)
      begin
        alm[k] = mask_tab[i][k] ? (8'hC0 | 8'($urandom)) : 8'($urandom & 32'h7F);
        i_host_bus.wr(ofs[k], alm[k]);
      end
      i_host_bus.rd(ofs[i % 4], rd_val);
      chk_byte("alarm readback", alm[i % 4], rd_val);
      for (int j = 0; j < 2; j++)
      begin
        flip = (j == 1) ? int'($urandom_range(3, 0)) : 4;
        @(posedge mclk);
        for (int k = 0; k < 4; k++)
          tim[k] <= (mask_tab[i][k] ? 8'($urandom) : alm[k]) ^ ((k == flip) ? 8'h01 : 8'h00);
        upd();
        wait_neg(2);
        chk_bit("alarm irq", !exp_hit(), irq_line);
        i_host_bus.rd(rtc_alarm_pkg::OFS_FLAGS, rd_val);
        chk_byte("alarm flags", exp_flags(exp_hit(), 1'b0, 1'b1), rd_val);
        wait_neg(1);
        chk_bit("irq released", 1'b1, irq_line);
      end
    end
    end_test("alarm masks");

    // Flag without enable, then set and clear in the same cycle
    for (int k = 0; k < 4; k++)
      alm[k] = 8'hFF;
    for (int k = 0; k < 4; k++)
      i_host_bus.wr(ofs[k], alm[k]);
    i_host_bus.wr(rtc_alarm_pkg::OFS_IRQ_CTRL, 8'h00);
    upd();
    wait_neg(3);
    chk_bit("irq disabled", 1'b1, irq_line);
    i_host_bus.rd(rtc_alarm_pkg::OFS_FLAGS, rd_val);
    chk_byte("flag without enable", exp_flags(1'b1, 1'b0, 1'b1), rd_val);
    i_host_bus.rd(rtc_alarm_pkg::OFS_FLAGS, rd_val);
    chk_byte("flags cleared", exp_flags(1'b0, 1'b0, 1'b1), rd_val);
    i_host_bus.wr(rtc_alarm_pkg::OFS_IRQ_CTRL, 8'h08);
    upd();
    fork
      i_host_bus.rd(rtc_alarm_pkg::OFS_FLAGS, rd_val);
      upd();
    join
    wait_neg(2);
    chk_bit("irq kept", 1'b0, irq_line);
    i_host_bus.rd(rtc_alarm_pkg::OFS_FLAGS, rd_val);
    chk_byte("event during read", exp_flags(1'b1, 1'b0, 1'b1), rd_val);
    end_test("enable and clear");

    // Battery backup: released unless backup alarm is enabled
    @(posedge mclk);
    backup_pin <= 1'b1;
    repeat (4) @(posedge mclk);
    upd();
    wait_neg(3);
    chk_bit("backup irq off", 1'b1, irq_line);
    i_host_bus.rd(rtc_alarm_pkg::OFS_FLAGS, rd_val);
    i_host_bus.wr(rtc_alarm_pkg::OFS_IRQ_CTRL, 8'h0A);
    upd();
    wait_neg(3);
    chk_bit("backup irq on", 1'b0, irq_line);
    i_host_bus.rd(rtc_alarm_pkg::OFS_FLAGS, rd_val);
    @(posedge mclk);
    backup_pin <= 1'b0;
    end_test("backup");

    // Supply fail, warning lead, then recovery
    i_host_bus.wr(rtc_alarm_pkg::OFS_IRQ_CTRL, 8'h04);
    repeat (4) @(posedge mclk);
    supply_fail_pin <= 1'b1;
    wait_neg(4);
    chk_bit("supply irq", 1'b0, irq_line);
    wait_neg(WARN - 2);
    chk_bit("reset held off", 1'b1, cpu_reset_n);
    wait_neg(1);
    chk_bit("cpu reset", 1'b0, cpu_reset_n);
    chk_bit("deselect", 1'b1, chip_deselect);
    @(posedge mclk);
    supply_fail_pin <= 1'b0;
    wait_neg(5);
    chk_bit("reset released", 1'b1, cpu_reset_n);
    i_host_bus.rd(rtc_alarm_pkg::OFS_FLAGS, rd_val);
    chk_byte("supply flag", exp_flags(1'b0, 1'b1, 1'b1), rd_val);
    end_test("supply fail");

    // Low cell at a fresh power-up
    @(posedge mclk);
    cell_low_pin <= 1'b1;
    rst <= 1'b1;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    repeat (8) @(posedge mclk);
    i_host_bus.rd(rtc_alarm_pkg::OFS_FLAGS, rd_val);
    chk_byte("cell low", exp_flags(1'b0, 1'b0, 1'b0), rd_val);
    i_host_bus.rd(rtc_alarm_pkg::OFS_IRQ_CTRL, rd_val);
    chk_byte("ctrl reset", 8'h00, rd_val);
    end_test("cell check");
    test_done();
  end
endmodule

`default_nettype wire
